// ==== src/ana_pkg.sv ====
/*
 * Constants, types and helpers shared by the auto-negotiation ability
 * register bank: register offsets, field positions, reset values,
 * selector encodings and the base page word layout.
 * Assumes a 16-bit management register space with 5-bit addresses.
 */
package ana_pkg;

	// ==========================================================
	// widths
	localparam int unsigned ADDR_W = 5;
	localparam int unsigned DATA_W = 16;

	// ==========================================================
	// register offsets
	localparam logic [4:0] OFS_PHY_CONTROL = 5'h00;
	localparam logic [4:0] OFS_NEG_STATUS  = 5'h01;
	localparam logic [4:0] OFS_LOCAL_ADV   = 5'h04;
	localparam logic [4:0] OFS_PARTNER     = 5'h05;

	// ==========================================================
	// field positions
	localparam int unsigned POS_RESTART    = 9;
	localparam int unsigned POS_PAGE_SEEN  = 0;
	localparam int unsigned POS_ABIL_HI    = 8;
	localparam int unsigned POS_ABIL_LO    = 5;
	localparam int unsigned POS_SEL_HI     = 4;
	localparam int unsigned POS_SEL_LO     = 0;

	// ==========================================================
	// reset values and fixed codes
	localparam logic [3:0]  RST_ABILITY    = 4'hf;
	localparam logic [15:0] RST_PARTNER    = 16'h0000;
	localparam logic [15:0] RST_RDATA      = 16'h0000;
	localparam logic [6:0]  RST_UPPER      = 7'h00;
	localparam logic [4:0]  SEL_LOCAL      = 5'h01;

	// ==========================================================
	// selector encodings
	localparam logic [4:0]  SEL_IEEE_8023  = 5'h01;
	localparam logic [4:0]  SEL_IEEE_8029  = 5'h02;
	localparam logic [4:0]  SEL_IEEE_8025  = 5'h03;
	localparam logic [4:0]  SEL_IEEE_1394  = 5'h04;

	typedef enum logic [2:0]
	{
		ANA_PROTO_RESERVED,
		ANA_PROTO_8023,
		ANA_PROTO_8029,
		ANA_PROTO_8025,
		ANA_PROTO_1394
	} ana_proto_type;

	// ==========================================================
	// base page word: upper bits, four ability bits, selector
	typedef struct packed
	{
		logic [6:0] upper;
		logic       ability_100tx_full;
		logic       ability_100tx_half;
		logic       ability_10t_full;
		logic       ability_10t_half;
		logic [4:0] selector;
	} ana_page_type;

	// register port request
	typedef struct packed
	{
		logic [4:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} ana_req_type;

	// ==========================================================
	// selector code to protocol
	function automatic ana_proto_type ana_decode_sel(input logic [4:0] sel);
		ana_proto_type p;
		p = ANA_PROTO_RESERVED;
		if (sel == SEL_IEEE_8023)
			p = ANA_PROTO_8023;
		else if (sel == SEL_IEEE_8029)
			p = ANA_PROTO_8029;
		else if (sel == SEL_IEEE_8025)
			p = ANA_PROTO_8025;
		else if (sel == SEL_IEEE_1394)
			p = ANA_PROTO_1394;
		return p;
	endfunction

endpackage

// ==== src/ana_sel_decode.sv ====
/*
 * Combinational decoder from a received selector field to a protocol code.
 * Assumes the selector comes from a register on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module ana_sel_decode
(
	input  wire logic [4:0]         sel,
	output ana_pkg::ana_proto_type  proto
);

	// ==========================================================
	// decode; 0x00 and 0x05-0x1f map to reserved
	always_comb
	begin
		proto = ana_pkg::ana_decode_sel(sel);
	end

endmodule

`default_nettype wire

// ==== src/ana_page_capture.sv ====
/*
 * Partner base page store and page-seen flag.
 * Assumes the negotiation logic presents a received page for one cycle
 * on the same clock, with valid high.
 */
`timescale 1ns/1ps
`default_nettype none

module ana_page_capture
(
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  rx_valid,
	input  wire ana_pkg::ana_page_type rx_word,
	input  wire logic                  restart,
	output ana_pkg::ana_page_type      page,
	output logic                       seen
);

	ana_pkg::ana_page_type page_r;
	ana_pkg::ana_page_type page_nxt;
	logic                  seen_r;
	logic                  seen_nxt;

	// ==========================================================
	// next values: store word unchanged, set beats restart clear
	always_comb
	begin
		page_nxt = page_r;
		seen_nxt = seen_r;
		if (restart)
			seen_nxt = 1'b0;
		if (rx_valid)
		begin
			page_nxt = rx_word;
			seen_nxt = 1'b1;
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			page_r <= ana_pkg::RST_PARTNER;
			seen_r <= 1'b0;
		end
		else
		begin
			page_r <= page_nxt;
			seen_r <= seen_nxt;
		end
	end

	assign page = page_r;
	assign seen = seen_r;

endmodule

`default_nettype wire

// ==== src/ana_regs.sv ====
/*
 * Auto-negotiation ability register bank: local advertisement register,
 * partner ability register, restart bit in the phy control register and
 * a negotiation status register, behind a simple strobe register port.
 * Assumes the negotiation engine on the same clock takes adv_page as the
 * base page to send when restart_pulse fires, and hands every received
 * partner base page in on page_rx_valid / page_rx_word.
 */
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - four writable ability bits, reset one, 8:5
// - cleared ability not advertised after restart
// - local selector 4:0 read-only, fixed 0x01
// - selector five bits wide, 32 codes
// - partner abilities captured, readable at 0x05
// - partner register reads zero after reset
// - partner selector decoded to protocol codes
module ana_regs
(
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire ana_pkg::ana_req_type  reg_req,
	output logic [15:0]                reg_rdata,
	output logic                       restart_pulse,
	output ana_pkg::ana_page_type      adv_page,
	input  wire logic                  page_rx_valid,
	input  wire ana_pkg::ana_page_type page_rx_word,
	output ana_pkg::ana_proto_type     partner_proto,
	output logic                       partner_page_seen
);

	// ==========================================================
	// local advertisement state
	logic [3:0]                ability_r;
	logic [3:0]                ability_nxt;
	ana_pkg::ana_page_type     adv_page_r;
	ana_pkg::ana_page_type     adv_page_nxt;
	logic                      restart_r;
	logic                      restart_nxt;

	// ==========================================================
	// read path and partner-side state
	logic [15:0]               rdata_r;
	logic [15:0]               rdata_nxt;
	ana_pkg::ana_proto_type    proto_r;
	ana_pkg::ana_proto_type    proto_nxt;
	ana_pkg::ana_proto_type    proto_dec;
	logic                      seen_r;
	logic                      seen_nxt;

	// ==========================================================
	// wires from the helpers
	ana_pkg::ana_page_type     partner_page;
	logic                      partner_seen;
	logic                      wr_ctrl;
	logic                      wr_adv;
	logic                      restart_req;
	ana_pkg::ana_page_type     local_word;

	// ==========================================================
	// write decode
	always_comb
	begin
		wr_ctrl = 1'b0;
		wr_adv  = 1'b0;
		if (reg_req.wr && reg_req.addr == ana_pkg::OFS_PHY_CONTROL)
			wr_ctrl = 1'b1;
		else if (reg_req.wr && reg_req.addr == ana_pkg::OFS_LOCAL_ADV)
			wr_adv = 1'b1;
	end

	// a restart is a control write with the restart bit set
	assign restart_req = wr_ctrl & reg_req.wdata[ana_pkg::POS_RESTART];

	// ==========================================================
	// current local word as software sees it
	always_comb
	begin
		local_word                    = '0;
		local_word.upper              = ana_pkg::RST_UPPER;
		local_word.ability_100tx_full = ability_r[3];
		local_word.ability_100tx_half = ability_r[2];
		local_word.ability_10t_full   = ability_r[1];
		local_word.ability_10t_half   = ability_r[0];
		local_word.selector           = ana_pkg::SEL_LOCAL;
	end

	// ==========================================================
	// local advertisement next values
	always_comb
	begin
		ability_nxt  = ability_r;
		adv_page_nxt = adv_page_r;
		restart_nxt  = 1'b0;
		if (wr_adv)
			ability_nxt = reg_req.wdata[ana_pkg::POS_ABIL_HI:ana_pkg::POS_ABIL_LO];
		if (restart_req)
		begin
			restart_nxt  = 1'b1;
			adv_page_nxt = local_word;
		end
	end

	// ==========================================================
	// local advertisement registers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ability_r           <= ana_pkg::RST_ABILITY;
			adv_page_r.upper    <= ana_pkg::RST_UPPER;
			adv_page_r.ability_100tx_full <= ana_pkg::RST_ABILITY[3];
			adv_page_r.ability_100tx_half <= ana_pkg::RST_ABILITY[2];
			adv_page_r.ability_10t_full   <= ana_pkg::RST_ABILITY[1];
			adv_page_r.ability_10t_half   <= ana_pkg::RST_ABILITY[0];
			adv_page_r.selector <= ana_pkg::SEL_LOCAL;
			restart_r           <= 1'b0;
		end
		else
		begin
			ability_r  <= ability_nxt;
			adv_page_r <= adv_page_nxt;
			restart_r  <= restart_nxt;
		end
	end

	// ==========================================================
	// partner page store
	ana_page_capture u_capture
	(
		.clk      (clk),
		.rst_n    (rst_n),
		.rx_valid (page_rx_valid),
		.rx_word  (page_rx_word),
		.restart  (restart_req),
		.page     (partner_page),
		.seen     (partner_seen)
	);

	// ==========================================================
	// partner selector decode
	ana_sel_decode u_decode
	(
		.sel   (partner_page.selector),
		.proto (proto_dec)
	);

	// ==========================================================
	// read mux; unmapped offsets and reserved bits read zero
	always_comb
	begin
		rdata_nxt = ana_pkg::RST_RDATA;
		if (reg_req.rd)
		begin
			if (reg_req.addr == ana_pkg::OFS_PHY_CONTROL)
				rdata_nxt = ana_pkg::RST_RDATA; // restart self-clears
			else if (reg_req.addr == ana_pkg::OFS_NEG_STATUS)
				rdata_nxt[ana_pkg::POS_PAGE_SEEN] = partner_seen;
			else if (reg_req.addr == ana_pkg::OFS_LOCAL_ADV)
				rdata_nxt = local_word;
			else if (reg_req.addr == ana_pkg::OFS_PARTNER)
				rdata_nxt = partner_page;
		end
	end

	// ==========================================================
	// partner-side output next values
	always_comb
	begin
		proto_nxt = proto_dec;
		seen_nxt  = partner_seen;
	end

	// ==========================================================
	// read data and partner-side output registers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rdata_r <= ana_pkg::RST_RDATA;
			proto_r <= ana_pkg::ANA_PROTO_RESERVED;
			seen_r  <= 1'b0;
		end
		else
		begin
			rdata_r <= rdata_nxt;
			proto_r <= proto_nxt;
			seen_r  <= seen_nxt;
		end
	end

	// ==========================================================
	// outputs, all straight from flip-flops
	assign reg_rdata         = rdata_r;
	assign restart_pulse     = restart_r;
	assign adv_page          = adv_page_r;
	assign partner_proto     = proto_r;
	assign partner_page_seen = seen_r;

endmodule

`default_nettype wire

// ==== tb/ana_regs_sva.sv ====
/* port checker for ana_regs
   assumes one clock and a synchronous active-low reset */
`timescale 1ns/1ps
`default_nettype none
module ana_regs_sva
(
	input wire logic                  clk,
	input wire logic                  rst_n,
	input wire ana_pkg::ana_req_type  reg_req,
	input wire logic [15:0]           reg_rdata,
	input wire logic                  restart_pulse,
	input wire ana_pkg::ana_page_type adv_page,
	input wire logic                  page_rx_valid,
	input wire ana_pkg::ana_page_type page_rx_word,
	input wire ana_pkg::ana_proto_type partner_proto,
	input wire logic                  partner_page_seen
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// register port and restart
	property p_rd_local;
		reg_req.rd && reg_req.addr == 5'h04 |=> reg_rdata[4:0] == 5'h01 && reg_rdata[15:9] == 7'h00;
	endproperty
	a_rd_local: assert property (p_rd_local) else $error("local selector wrong");
	property p_restart;
		reg_req.wr && reg_req.addr == 5'h00 && reg_req.wdata[9] |=> restart_pulse;
	endproperty
	a_restart: assert property (p_restart) else $error("restart pulse missing");
	property p_pulse_cause;
		restart_pulse |-> $past(reg_req.wr) && $past(reg_req.addr) == 5'h00 && $past(reg_req.wdata[9]);
	endproperty
	a_pulse_cause: assert property (p_pulse_cause) else $error("restart pulse without write");
	property p_adv_sel;
		adv_page.selector == 5'h01 && adv_page.upper == 7'h00;
	endproperty
	a_adv_sel: assert property (p_adv_sel) else $error("sent selector wrong");
	property p_adv_hold;
		$past(rst_n) && !restart_pulse |-> $stable(adv_page);
	endproperty
	a_adv_hold: assert property (p_adv_hold) else $error("sent page changed");
	// ==========================================================
	// partner page
	property p_seen;
		page_rx_valid |-> ##2 partner_page_seen;
	endproperty
	a_seen: assert property (p_seen) else $error("page not flagged");
	property p_proto_8025;
		page_rx_valid && page_rx_word.selector == 5'h03 ##1 !page_rx_valid |=> partner_proto == ana_pkg::ANA_PROTO_8025;
	endproperty
	a_proto_8025: assert property (p_proto_8025) else $error("decode wrong");
	property p_proto_rsvd;
		page_rx_valid && page_rx_word.selector > 5'h04 ##1 !page_rx_valid
			|=> partner_proto == ana_pkg::ANA_PROTO_RESERVED;
	endproperty
	a_proto_rsvd: assert property (p_proto_rsvd) else $error("reserved decode wrong");
	property p_after_reset;
		$rose(rst_n) |-> adv_page == 16'h01e1 && !partner_page_seen && partner_proto == ana_pkg::ANA_PROTO_RESERVED;
	endproperty
	a_after_reset: assert property (p_after_reset) else $error("reset state wrong");
	c_restart: cover property (restart_pulse);
	c_page: cover property (page_rx_valid ##2 partner_page_seen);
	c_rd_partner: cover property (reg_req.rd && reg_req.addr == 5'h05);
endmodule
bind ana_regs ana_regs_sva i_ana_regs_sva (.clk, .rst_n, .reg_req, .reg_rdata, .restart_pulse, .adv_page,
	.page_rx_valid, .page_rx_word, .partner_proto, .partner_page_seen);
`default_nettype wire

// ==== tb/ana_link_partner.sv ====
/* remote link partner model: hears our page, answers with its own
   assumes restart_pulse and adv_page from ana_regs on the same clock */
`timescale 1ns/1ps
`default_nettype none
module ana_link_partner
(
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  restart_pulse,
	input  wire ana_pkg::ana_page_type adv_page,
	input  wire logic                  slow,
	input  wire ana_pkg::ana_page_type own_page,
	output ana_pkg::ana_page_type      heard_page,
	output logic                       page_rx_valid,
	output ana_pkg::ana_page_type      page_rx_word
);
	logic [3:0] wait_r;
	logic       busy_r;
	// answer a restart after a short or long pause
	always_ff @(posedge clk)
	begin
		page_rx_valid <= 1'b0;
		page_rx_word  <= ~page_rx_word; // word line not held between pages
		if (!rst_n)
		begin
			busy_r       <= 1'b0;
			page_rx_word <= 16'h0000;
		end
		else if (restart_pulse)
		begin
			heard_page <= adv_page;
			busy_r     <= 1'b1;
			wait_r     <= slow ? 4'hc : 4'h2;
		end
		else if (busy_r && wait_r == 4'h0)
		begin
			busy_r        <= 1'b0;
			page_rx_valid <= 1'b1;
			page_rx_word  <= own_page; // abilities and selector as one word
		end
		else if (busy_r)
			wait_r <= wait_r - 4'h1;
	end
endmodule
`default_nettype wire

// ==== tb/ana_regs_tb.sv ====
/* self-checking bench for ana_regs with a link partner model
   assumes nothing beyond the design package */
`timescale 1ns/1ps
`default_nettype none
module ana_regs_tb;
	logic                   clk = 1'b0;
	logic                   rst_n = 1'b0;
	ana_pkg::ana_req_type   reg_req = '0;
	logic [15:0]            reg_rdata;
	logic                   restart_pulse, page_rx_valid, partner_page_seen;
	ana_pkg::ana_page_type  adv_page, page_rx_word, heard_page;
	ana_pkg::ana_page_type  own_page = 16'h0000;
	ana_pkg::ana_proto_type partner_proto;
	logic                   slow = 1'b0;
	logic                   pend = 1'b0;
	logic                   seen_d = 1'b0;
	logic [15:0]            rd_q[$], adv_q[$], w;
	ana_pkg::ana_proto_type proto_q[$];
	logic [4:0]             sel_tab[6] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h00, 5'h1f};
	int                     num_errors = 0, comparisons = 0, i, n, seed;
	ana_regs i_ana_regs (.clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.restart_pulse(restart_pulse), .adv_page(adv_page), .page_rx_valid(page_rx_valid),
		.page_rx_word(page_rx_word), .partner_proto(partner_proto), .partner_page_seen(partner_page_seen));
	ana_link_partner i_ana_link_partner (.clk(clk), .rst_n(rst_n), .restart_pulse(restart_pulse),
		.adv_page(adv_page), .slow(slow), .own_page(own_page), .heard_page(heard_page),
		.page_rx_valid(page_rx_valid), .page_rx_word(page_rx_word));
	// clock, 100 ns period
	initial
	begin
		forever #50 clk = ~clk;
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// one bus cycle; strobes stay until the next call
	task automatic bus(input logic wr, input logic rd, input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_req <= '{a, d, wr, rd};
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] exp);
		rd_q.push_back(exp);
		bus(1'b0, 1'b1, a, 16'h0000);
	endtask
	// result watcher: read data, sent page, decoded protocol
	always @(negedge clk)
	begin
		if (pend)
			check("reg_rdata", reg_rdata, rd_q.pop_front());
		else if (rst_n)
			check("idle reg_rdata", reg_rdata, 16'h0000);
		pend = reg_req.rd;
		if (restart_pulse)
			check("adv_page", adv_page, adv_q.pop_front());
		if (partner_page_seen && !seen_d)
			check("partner_proto", 16'(partner_proto), 16'(proto_q.pop_front()));
		seen_d = partner_page_seen;
	end
	initial
	begin
		#(100 * 4000);
		num_errors++;
		summarize();
	end
	initial
	begin
		seed = $urandom(92978);
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd(5'h04, 16'h01e1);
		rd(5'h05, 16'h0000);
		bus(1'b1, 1'b0, 5'h05, 16'hffff);
		rd(5'h05, 16'h0000);
		rd(5'h1f, 16'h0000);
		bus(1'b1, 1'b0, 5'h04, 16'h0000);
		rd(5'h04, 16'h0001);
		for (i = 0; i < 6; i++)
		begin
			w = 16'($urandom);
			bus(1'b1, 1'b0, 5'h04, w);
			rd(5'h04, {7'h00, w[8:5], 5'h01});
		end
		$display("test local_register done");
		for (i = 0; i < 6; i++)
		begin
			w = 16'($urandom);
			bus(1'b1, 1'b0, 5'h04, w);
			adv_q.push_back({7'h00, w[8:5], 5'h01});
			proto_q.push_back(ana_pkg::ana_proto_type'(sel_tab[i] < 5'h05 ? sel_tab[i] : 5'h00));
			own_page <= {7'($urandom), 4'($urandom), sel_tab[i]};
			slow <= i[0];
			bus(1'b1, 1'b0, 5'h00, 16'h0200);
			bus(1'b0, 1'b0, 5'h00, 16'h0000);
			// old page flag drops one cycle after the pulse
			repeat (2) @(negedge clk);
			check("seen after restart", 16'(partner_page_seen), 16'h0000);
			n = 0;
			while (!partner_page_seen && n < 40)
			begin
				@(negedge clk);
				n++;
			end
			if (n == 40)
				num_errors++;
			check("heard_page", heard_page, {7'h00, w[8:5], 5'h01});
			rd(5'h05, own_page);
			rd(5'h01, 16'h0001);
			bus(1'b0, 1'b0, 5'h00, 16'h0000);
		end
		$display("test partner_pages done");
		repeat (2) @(posedge clk);
		summarize();
	end
endmodule
`default_nettype wire
